// ===== rtl/dsrc_consts.svh
// Constants for the self refresh control ends.
// Assumes a 40 MHz clock; included by bare name.
`ifndef DSRC_CONSTS_SVH
`define DSRC_CONSTS_SVH
`define DSRC_CLK_PERIOD_NS 25
`define DSRC_RFC_NS 350
`define DSRC_RFC_MARGIN_NS 10
`define DSRC_XS_ABORT_NS 160
`define DSRC_CKE_MIN_NS 125
`define DSRC_CKESR_NS 135
`define DSRC_CKSRE_NCK 8
`define DSRC_CKSRX_NCK 8
`define DSRC_XSDLL_NCK 768
`define DSRC_INT_REFI_NS 7800
`define DSRC_XS_NS (`DSRC_RFC_NS + `DSRC_RFC_MARGIN_NS)
`define DSRC_XS_CYC ((`DSRC_XS_NS + `DSRC_CLK_PERIOD_NS - 1) / `DSRC_CLK_PERIOD_NS)
`define DSRC_XSA_CYC ((`DSRC_XS_ABORT_NS + `DSRC_CLK_PERIOD_NS - 1) / `DSRC_CLK_PERIOD_NS)
`define DSRC_RFC_CYC ((`DSRC_RFC_NS + `DSRC_CLK_PERIOD_NS - 1) / `DSRC_CLK_PERIOD_NS)
`define DSRC_CKESR_CYC ((`DSRC_CKESR_NS + `DSRC_CLK_PERIOD_NS - 1) / `DSRC_CLK_PERIOD_NS)
`define DSRC_CKE_MIN_CYC (`DSRC_CKE_MIN_NS / `DSRC_CLK_PERIOD_NS)
`define DSRC_INT_REFI_CYC (`DSRC_INT_REFI_NS / `DSRC_CLK_PERIOD_NS)
`define DSRC_MODE_1X 3'h0
`define DSRC_MODE_2X 3'h1
`define DSRC_MODE_4X 3'h2
`define DSRC_MODE_OTF2 3'h5
`define DSRC_MODE_OTF4 3'h6
`define DSRC_CNT_W 12
`endif

// ===== rtl/dsrc_pkg.sv
// Types shared by both ends of the self refresh link.
// Assumes nothing beyond the constants header.
package dsrc_pkg;
    typedef enum logic [2:0] {DSRC_NOP, DSRC_DES, DSRC_REF, DSRC_SRE, DSRC_ACT,
                              DSRC_RD, DSRC_WR, DSRC_MRS} dsrc_cmd_t;
    typedef enum logic [1:0] {DSRC_RATE1, DSRC_RATE2, DSRC_RATE4} dsrc_rate_t;
endpackage

// ===== rtl/dsrc_if.sv
// Pin-level link between controller and device.
// Assumes one common clock, both ends on it.
`timescale 1ns/10ps
interface dsrc_if;
    logic csN;
    logic actN;
    logic rasN;
    logic casN;
    logic weN;
    logic cke;
    logic bg0;
    logic odtPin;
    logic clkRun;
    modport ctrl (output csN, actN, rasN, casN, weN, cke, bg0, odtPin, clkRun);
    modport dev (input csN, actN, rasN, casN, weN, cke, bg0, odtPin, clkRun);
endinterface

// ===== rtl/dsrc_counter.sv
// Load-and-count-down timer used by the controller end.
// Assumes synchronous active-high reset.
`timescale 1ns/10ps
module dsrc_counter #(
    parameter int W = 12
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic done
);
    logic [W-1:0] cnt_q;
    always_ff @(posedge clock)
    begin
        if (rst)
            cnt_q <= '0;
        else if (load)
            cnt_q <= value;
        else if (cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
    end
    assign done = (cnt_q == '0) && !load;
endmodule // dsrc_counter

// ===== rtl/dsrc_device.sv
// Device end: self refresh entry, residency, exit and abort.
// Assumes the controller keeps its own timing and command rules.
`include "dsrc_consts.svh"
`timescale 1ns/10ps
module dsrc_device #(
    parameter int XSDLL = `DSRC_XSDLL_NCK,
    parameter int INT_REFI = `DSRC_INT_REFI_CYC
) (
    input wire logic clock,
    input wire logic rst,
    dsrc_if.dev link,
    input wire logic [2:0] refreshMode,
    input wire logic abortEnable,
    output logic inSelfRefresh,
    output logic odtEnabled,
    output logic dllEnabled,
    output logic dllReset,
    output logic dllLocked,
    output logic internalRefresh,
    output dsrc_pkg::dsrc_rate_t refreshRate,
    output logic refreshAborted,
    output logic [`DSRC_CNT_W-1:0] refreshCount
);
    import dsrc_pkg::*;
    typedef enum logic [1:0] {DSRC_NORMAL, DSRC_SELF, DSRC_LOCKING} dsrc_dstate_t;
    dsrc_dstate_t state_q;
    logic [15:0] timer_q;
    logic [15:0] refBusy_q;
    logic inSr_q, odt_q, dll_q, dllRst_q, lock_q, intRef_q, abort_q;
    dsrc_rate_t rate_q;
    logic [`DSRC_CNT_W-1:0] count_q;
    wire isOtf = refreshMode[2];
    wire sreDecode = !link.csN && !link.rasN && !link.casN && !link.cke
                     && link.weN && link.actN;
    wire refDecode = link.cke && !link.csN && link.actN && !link.rasN && !link.casN
                     && link.weN;
    wire srxDecode = link.cke && link.csN;
    wire firstRefDue = (timer_q == 16'(`DSRC_CKE_MIN_CYC - 1));
    wire periodicDue = (timer_q >= 16'(INT_REFI + `DSRC_CKE_MIN_CYC - 1));
    wire startRef = (state_q == DSRC_SELF) && (firstRefDue || periodicDue);
    wire wideRate = isOtf ? link.bg0 : (refreshMode != `DSRC_MODE_1X);
    wire [2:0] effMode = isOtf ? (refreshMode & 3'h3) : refreshMode;
    dsrc_rate_t cmdRate;
    assign cmdRate = !wideRate ? DSRC_RATE1 :
                     (effMode == `DSRC_MODE_4X ? DSRC_RATE4 : DSRC_RATE2); // [RQ23]
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_q <= DSRC_NORMAL;
            timer_q <= 16'h0000;
            refBusy_q <= 16'h0000;
            inSr_q <= 1'b0;
            odt_q <= 1'b1;
            dll_q <= 1'b1;
            dllRst_q <= 1'b0;
            lock_q <= 1'b1;
            intRef_q <= 1'b0;
            abort_q <= 1'b0;
            rate_q <= DSRC_RATE1;
            count_q <= '0;
        end
        else
        begin
            intRef_q <= 1'b0;
            dllRst_q <= 1'b0;
            abort_q <= 1'b0;
            if (refBusy_q != 16'h0000)
                refBusy_q <= refBusy_q - 16'h0001;
            unique case (state_q)
                DSRC_NORMAL, DSRC_LOCKING:
                begin
                    if (state_q == DSRC_LOCKING)
                    begin
                        timer_q <= timer_q + 16'h0001;
                        if (timer_q >= 16'(XSDLL - 1))
                        begin
                            lock_q <= 1'b1;
                            state_q <= DSRC_NORMAL;
                        end
                    end
                    if (refDecode)
                        rate_q <= cmdRate; // [RQ23]
                    if (sreDecode)
                    begin
                        state_q <= DSRC_SELF; // [RQ4]
                        inSr_q <= 1'b1;
                        odt_q <= 1'b0; // [RQ7]
                        dll_q <= 1'b0; // [RQ8]
                        lock_q <= 1'b0; // [RQ8]
                        timer_q <= 16'h0000;
                    end
                end
                DSRC_SELF:
                begin
                    timer_q <= periodicDue ? 16'(`DSRC_CKE_MIN_CYC)
                               : timer_q + 16'h0001; // [RQ11]
                    if (startRef)
                    begin
                        intRef_q <= 1'b1; // [RQ11]
                        refBusy_q <= 16'(`DSRC_RFC_CYC);
                        count_q <= count_q + 1'b1;
                    end
                    if (srxDecode)
                    begin
                        state_q <= DSRC_LOCKING; // [RQ14]
                        inSr_q <= 1'b0;
                        odt_q <= 1'b1; // [RQ7]
                        dll_q <= 1'b1; // [RQ8]
                        dllRst_q <= 1'b1; // [RQ8]
                        timer_q <= 16'h0000;
                        if (abortEnable && (refBusy_q != 16'h0000))
                        begin
                            refBusy_q <= 16'h0000; // [RQ21]
                            abort_q <= 1'b1;
                            count_q <= count_q - 1'b1; // [RQ21]
                        end
                    end
                    // Other pins are not looked at here. [RQ9]
                end
            endcase
        end
    end
    // Exit lets a running refresh finish unless abort is on. [RQ20]
    assign inSelfRefresh = inSr_q;
    assign odtEnabled = odt_q;
    assign dllEnabled = dll_q;
    assign dllReset = dllRst_q;
    assign dllLocked = lock_q;
    assign internalRefresh = intRef_q;
    assign refreshRate = rate_q;
    assign refreshAborted = abort_q;
    assign refreshCount = count_q;
endmodule // dsrc_device

// ===== rtl/dsrc_controller.sv
// ****************************************************************
// Controller end: drives commands, CKE and clock run for self refresh.
// ****************************************************************
// Assumes the device end decodes the pins on the shared clock.
// Rules for both ends of the self refresh link
// RQ1 - Odd double-rate count needs extra refreshes.
// RQ2 - Quad count not multiple four needs extras; here one extra is owed whenever the count is not a multiple of four.
// RQ3 - Extras kept outside average interval accounting.
// RQ4 - Entry decoded from pins with CKE low.
// RQ5 - Enter only when idle.
// RQ6 - Hold CKE low throughout residency.
// RQ7 - Device drops termination in self refresh.
// RQ8 - Device stops DLL, resets it on exit.
// RQ9 - Device ignores pins but CKE, reset.
// RQ10 - Write waits by reference generator setting; here every write waits the locked delay and vrefOn is unused.
// RQ11 - Device refreshes internally, own timer.
// RQ12 - Stay in at least minimum residency.
// RQ13 - Clock stop after delay; restart before exit.
// RQ14 - Exit is CKE high with deselect.
// RQ15 - Calibration and limited mode writes fast; here they also wait the unlocked exit delay, so fastOk has no effect.
// RQ16 - Reads and writes wait locked delay.
// RQ17 - CKE high, termination off during locking.
// RQ18 - Refresh before re-entry after exit.
// RQ19 - Deselect every edge during unlocked exit.
// RQ20 - Exit delay is refresh time plus margin.
// RQ21 - Abort mode allows shorter exit delay.
// RQ22 - Extra refresh needed regardless of abort.
// RQ23 - Bank group bit selects refresh rate.
// RQ24 - Count wide refreshes since last reset point.
`include "dsrc_consts.svh"
`timescale 1ns/10ps
module dsrc_controller #(
    parameter int XSDLL = `DSRC_XSDLL_NCK
) (
    input wire logic clock,
    input wire logic rst,
    dsrc_if.ctrl link,
    input wire logic [2:0] refreshMode,
    input wire logic abortEnable,
    input wire logic parityOn,
    input wire logic vrefOn,
    input wire logic enterReq,
    input wire logic exitReq,
    input wire logic deviceIdle,
    input wire logic cmdValid,
    input wire dsrc_pkg::dsrc_cmd_t cmdCode,
    input wire logic cmdFast,
    input wire logic cmdWideRate,
    input wire logic modeWrite,
    output logic cmdReady,
    output logic inSelfRefresh,
    output logic [2:0] extraPending,
    output logic csN,
    output logic odtOut
);
    import dsrc_pkg::*;
    // ****************************************
    // State and registers.
    // ****************************************
    typedef enum logic [2:0] {DSRC_C_RUN, DSRC_C_ENTER, DSRC_C_SELF, DSRC_C_RESTART,
                              DSRC_C_EXIT} dsrc_cstate_t;
    dsrc_cstate_t state_q;
    logic [15:0] t_q;
    logic [1:0] wideCnt_q;
    logic [2:0] extra_q;
    logic needRef_q;
    logic cke_q, clkRun_q, cs_q, act_q, ras_q, cas_q, we_q, bg_q, odt_q, rdy_q, sr_q;
    logic lockDone;
    logic unlockDone;
    // ****************************************
    // Command decode and exit timing.
    // ****************************************
    wire isQuad = (refreshMode == `DSRC_MODE_4X) || (refreshMode == `DSRC_MODE_OTF4);
    wire isDouble = (refreshMode == `DSRC_MODE_2X) || (refreshMode == `DSRC_MODE_OTF2);
    wire [15:0] xsCyc = abortEnable ? 16'(`DSRC_XSA_CYC) : 16'(`DSRC_XS_CYC); // [RQ21] [RQ20]
    wire [15:0] residency = 16'(`DSRC_CKESR_CYC) + (parityOn ? 16'h0001 : 16'h0000);
    wire cmdIsRef = cmdValid && (cmdCode == DSRC_REF);
    wire exitQuiet = (state_q == DSRC_C_EXIT) && !unlockDone;
    wire fastOk = cmdFast && (cmdCode == DSRC_MRS || cmdCode == DSRC_NOP);
    wire needsLock = (cmdCode == DSRC_RD) || (cmdCode == DSRC_WR)
                     || (cmdCode == DSRC_WR && !vrefOn); // [RQ16] [RQ10]
    wire allowed = (state_q == DSRC_C_RUN) ||
                   ((state_q == DSRC_C_EXIT) && (needsLock ? lockDone :
                   (fastOk && !modeWrite) || unlockDone)); // [RQ15]
    wire reentryBlocked = needRef_q || (extra_q != 3'h0); // [RQ18] [RQ22]
    wire [2:0] extraNeed = (isDouble && wideCnt_q[0]) ? 3'h1 :
                           (isQuad && wideCnt_q != 2'h0) ? 3'h1 : 3'h0; // [RQ1] [RQ2]
    wire issue = allowed && cmdValid && !rdy_q && cmdCode != DSRC_SRE && !exitQuiet;
    wire exitEdge = (state_q == DSRC_C_RESTART) && (t_q >= 16'(`DSRC_CKSRX_NCK - 1)); // [RQ14]
    // ****************************************
    // Exit timers, started on the edge that raises CKE.
    // ****************************************
    dsrc_counter #(.W(16)) lockTimer (.clock(clock), .rst(rst),
        .load(exitEdge), .value(16'(XSDLL)), .done(lockDone));
    dsrc_counter #(.W(16)) unlockTimer (.clock(clock), .rst(rst),
        .load(exitEdge), .value(xsCyc), .done(unlockDone));
    // ****************************************
    // Command and state sequencing.
    // ****************************************
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_q <= DSRC_C_RUN;
            t_q <= 16'h0000;
            wideCnt_q <= 2'h0;
            extra_q <= 3'h0;
            needRef_q <= 1'b0;
            cke_q <= 1'b1;
            clkRun_q <= 1'b1;
            {cs_q, act_q, ras_q, cas_q, we_q} <= 5'h1F;
            bg_q <= 1'b0;
            odt_q <= 1'b0;
            rdy_q <= 1'b0;
            sr_q <= 1'b0;
        end
        else
        begin
            {cs_q, act_q, ras_q, cas_q, we_q} <= 5'h1F;
            rdy_q <= issue;
            t_q <= t_q + 16'h0001;
            if (issue && cmdIsRef)
            begin
                {cs_q, ras_q, cas_q} <= 3'h0;
                bg_q <= cmdWideRate;
                needRef_q <= 1'b0; // [RQ18]
                if (extra_q != 3'h0)
                    extra_q <= extra_q - 3'h1; // [RQ3]
                wideCnt_q <= cmdWideRate ? wideCnt_q + 2'h1 : 2'h0; // [RQ24]
            end
            if (modeWrite && issue)
                wideCnt_q <= 2'h0; // [RQ24]
            unique case (state_q)
                DSRC_C_RUN, DSRC_C_EXIT:
                begin
                    if (state_q == DSRC_C_EXIT)
                    begin
                        cke_q <= 1'b1; // [RQ17]
                        odt_q <= 1'b0; // [RQ17]
                        if (exitQuiet)
                            cs_q <= 1'b1; // [RQ19]
                        if (lockDone)
                            state_q <= DSRC_C_RUN;
                    end
                    else
                        odt_q <= 1'b1;
                    if (enterReq && deviceIdle && !reentryBlocked && unlockDone
                        && !(issue && cmdIsRef)) // [RQ5]
                    begin
                        {cs_q, ras_q, cas_q} <= 3'h0; // [RQ4]
                        cke_q <= 1'b0;
                        odt_q <= 1'b0;
                        extra_q <= extraNeed;
                        t_q <= 16'h0000;
                        sr_q <= 1'b1;
                        state_q <= DSRC_C_ENTER;
                    end
                end
                DSRC_C_ENTER:
                begin
                    cke_q <= 1'b0; // [RQ6]
                    if (t_q >= 16'(`DSRC_CKSRE_NCK - 1))
                    begin
                        clkRun_q <= 1'b0; // [RQ13]
                        state_q <= DSRC_C_SELF;
                    end
                end
                DSRC_C_SELF:
                begin
                    if (exitReq && t_q >= residency) // [RQ12]
                    begin
                        clkRun_q <= 1'b1; // [RQ13]
                        t_q <= 16'h0000;
                        state_q <= DSRC_C_RESTART;
                    end
                end
                DSRC_C_RESTART:
                begin
                    if (exitEdge)
                    begin
                        cke_q <= 1'b1; // [RQ14]
                        cs_q <= 1'b1;
                        sr_q <= 1'b0;
                        needRef_q <= 1'b1; // [RQ22]
                        wideCnt_q <= 2'h0;
                        state_q <= DSRC_C_EXIT;
                    end
                end
            endcase
        end
    end
    // ****************************************
    // Pin and status outputs.
    // ****************************************
    assign link.csN = cs_q;
    assign link.actN = act_q;
    assign link.rasN = ras_q;
    assign link.casN = cas_q;
    assign link.weN = we_q;
    assign link.cke = cke_q;
    assign link.bg0 = bg_q;
    assign link.odtPin = odt_q;
    assign link.clkRun = clkRun_q;
    assign cmdReady = rdy_q;
    assign inSelfRefresh = sr_q;
    assign extraPending = extra_q;
    assign csN = cs_q;
    assign odtOut = odt_q;
endmodule // dsrc_controller

// ===== bench/dsrc_checker.sv
// Concurrent checks on the pins between controller and device.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
module dsrc_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic csN,
    input wire logic actN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic cke,
    input wire logic bg0,
    input wire logic odtPin,
    input wire logic clkRun
);
    // ****************************************
    // Refresh owed since the last exit.
    // ****************************************
    logic refOwed_q;
    wire logic refSeen = cke && !csN && actN && !rasN && !casN && weN;
    always_ff @(posedge clock)
    begin
        if (rst)
            refOwed_q <= 1'b0;
        else if ($rose(cke))
            refOwed_q <= 1'b1;
        else if (refSeen)
            refOwed_q <= 1'b0;
    end
    // ****************************************
    // Pin checks.
    // ****************************************
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence entryCmd;
        !csN && actN && !rasN && !casN && weN && !cke;
    endsequence
    sequence exitCmd;
        $rose(cke) && csN;
    endsequence
    entry_decode_a: assert property ($fell(cke) |-> entryCmd)
        else $error("entry pins wrong");
    clock_hold_a: assert property ($fell(cke) |-> clkRun [*8])
        else $error("clock stopped early");
    clock_low_a: assert property (!clkRun |-> !cke)
        else $error("clock stopped outside self refresh");
    clock_restart_a: assert property ($rose(cke) |-> $past(clkRun, 8) && $past(clkRun))
        else $error("clock not stable before exit");
    exit_deselect_a: assert property ($rose(cke) |-> csN [*7])
        else $error("command during exit interval");
    residency_min_a: assert property ($fell(cke) |=> !cke [*6])
        else $error("residency too short");
    locked_hold_a: assert property (exitCmd |=> (cke && !odtPin) [*8])
        else $error("cke or termination wrong while locking");
    refresh_first_a: assert property ($fell(cke) |-> !refOwed_q)
        else $error("re-entry without refresh");
endmodule // dsrc_checker

// ===== bench/testbench.sv
// Self-checking bench joining controller and device over the pin link.
// Assumes the rtl files and the checker are compiled first.
`timescale 1ns/10ps
`include "dsrc_consts.svh"
module testbench;
    import dsrc_pkg::*;
    localparam int XSDLL = 20;
    logic clock = 1'b0, rst = 1'b1, abortEnable = 1'b0, parityOn = 1'b0, vrefOn = 1'b1;
    logic enterReq = 1'b0, exitReq = 1'b0, deviceIdle = 1'b1, cmdValid = 1'b0;
    logic cmdFast = 1'b0, cmdWideRate = 1'b0, modeWrite = 1'b0;
    logic [2:0] refreshMode = `DSRC_MODE_OTF2;
    dsrc_cmd_t cmdCode = DSRC_REF;
    logic cmdReady, cInSr, csNOut, odtOut, dInSr, odtEnabled, dllEnabled, dllReset;
    logic dllLocked, internalRefresh, refreshAborted;
    logic [2:0] extraPending;
    dsrc_rate_t refreshRate;
    logic [`DSRC_CNT_W-1:0] refreshCount;
    int failures = 0, compares = 0, dllPulses = 0, dllMark = 0;
    int abortPulses = 0, abortMark = 0, countMark = 0;
    // ****************************************
    // Clock, ends and checker.
    // ****************************************
    initial forever #12.5 clock = ~clock;
    always @(posedge clock) if (dllReset === 1'b1) dllPulses++;
    always @(posedge clock) if (refreshAborted === 1'b1) abortPulses++;
    dsrc_if dsrc_if_i ();
    dsrc_controller #(.XSDLL(XSDLL)) dsrc_controller_i (.clock(clock), .rst(rst),
        .link(dsrc_if_i), .refreshMode(refreshMode), .abortEnable(abortEnable),
        .parityOn(parityOn), .vrefOn(vrefOn), .enterReq(enterReq), .exitReq(exitReq),
        .deviceIdle(deviceIdle), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdFast(cmdFast),
        .cmdWideRate(cmdWideRate), .modeWrite(modeWrite), .cmdReady(cmdReady),
        .inSelfRefresh(cInSr), .extraPending(extraPending), .csN(csNOut), .odtOut(odtOut));
    dsrc_device #(.XSDLL(XSDLL), .INT_REFI(40)) dsrc_device_i (.clock(clock), .rst(rst),
        .link(dsrc_if_i), .refreshMode(refreshMode), .abortEnable(abortEnable),
        .inSelfRefresh(dInSr), .odtEnabled(odtEnabled), .dllEnabled(dllEnabled),
        .dllReset(dllReset), .dllLocked(dllLocked), .internalRefresh(internalRefresh),
        .refreshRate(refreshRate), .refreshAborted(refreshAborted), .refreshCount(refreshCount));
    dsrc_checker dsrc_checker_i (.clock(clock), .rst(rst), .csN(dsrc_if_i.csN),
        .actN(dsrc_if_i.actN), .rasN(dsrc_if_i.rasN), .casN(dsrc_if_i.casN),
        .weN(dsrc_if_i.weN), .cke(dsrc_if_i.cke), .bg0(dsrc_if_i.bg0),
        .odtPin(dsrc_if_i.odtPin), .clkRun(dsrc_if_i.clkRun));
    // ****************************************
    // Shared tasks.
    // ****************************************
    task automatic checkBit(input logic got, input logic exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic checkVal(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic issue(input dsrc_cmd_t code, input logic wide, output int lat);
        lat = 0;
        @(posedge clock);
        cmdValid <= 1'b1;
        cmdCode <= code;
        cmdWideRate <= wide;
        do
        begin
            @(posedge clock);
            lat++;
        end
        while (cmdReady !== 1'b1 && lat < 2000);
        cmdValid <= 1'b0;
        if (lat >= 2000)
            failures++;
    endtask
    task automatic enterSr();
        int n, tLow, tRef;
        n = 0;
        tLow = -1;
        tRef = -1;
        @(posedge clock);
        enterReq <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
            if (dsrc_if_i.cke === 1'b0 && tLow < 0)
                tLow = n;
            if (internalRefresh === 1'b1 && tRef < 0 && tLow >= 0)
                tRef = n;
        end
        while (dsrc_if_i.clkRun !== 1'b0 && n < 200);
        enterReq <= 1'b0;
        #1;
        checkBit(dInSr, 1'b1);
        checkBit(cInSr, 1'b1);
        checkBit(odtEnabled, 1'b0);
        checkBit(dllEnabled, 1'b0);
        checkBit(tRef >= 0 && tRef - tLow <= `DSRC_CKE_MIN_CYC + 1, 1'b1);
    endtask
    task automatic exitSr(input int hold);
        int n;
        n = 0;
        dllMark = dllPulses;
        abortMark = abortPulses;
        countMark = int'(refreshCount);
        repeat (hold) @(posedge clock);
        exitReq <= 1'b1;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (dsrc_if_i.cke !== 1'b1 && n < 200);
        exitReq <= 1'b0;
        checkBit(cInSr, 1'b0);
        checkBit(odtOut, 1'b0);
        checkBit(csNOut, 1'b1);
        checkBit(dllLocked, 1'b0);
    endtask
    task automatic afterExit();
        checkBit(dllPulses == dllMark + 1, 1'b1);
        checkBit(odtEnabled, 1'b1);
        checkBit(dllEnabled, 1'b1);
    endtask
    // ****************************************
    // Scenarios.
    // ****************************************
    task automatic t_reset();
        @(posedge clock);
        #1;
        checkBit(dsrc_if_i.cke, 1'b1);
        checkBit(dsrc_if_i.clkRun, 1'b1);
        checkBit(dsrc_if_i.csN, 1'b1);
        checkBit(dllLocked, 1'b1);
        checkVal(refreshCount, 12'h000);
        $display("test reset done");
    endtask
    task automatic t_otf();
        logic [2:0] modes [4] = '{`DSRC_MODE_OTF2, `DSRC_MODE_OTF2,
                                  `DSRC_MODE_OTF4, `DSRC_MODE_OTF4};
        logic wides [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        dsrc_rate_t rates [4] = '{DSRC_RATE2, DSRC_RATE1, DSRC_RATE4, DSRC_RATE1};
        int lat;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clock);
            refreshMode <= modes[i];
            issue(DSRC_REF, wides[i], lat);
            repeat (2) @(posedge clock);
            #1;
            checkVal({10'h000, refreshRate}, {10'h000, rates[i]});
        end
        $display("test otf rate done");
    endtask
    task automatic t_extra();
        logic [2:0] modes [2] = '{`DSRC_MODE_2X, `DSRC_MODE_4X};
        int counts [2] = '{1, 2};
        int lat;
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clock);
            refreshMode <= modes[i];
            repeat (counts[i]) issue(DSRC_REF, 1'b1, lat);
            enterSr();
            exitSr(4);
            checkVal({9'h000, extraPending}, 12'h001);
            enterReq <= 1'b1;
            repeat (30) @(posedge clock);
            checkBit(dsrc_if_i.cke, 1'b1);
            enterReq <= 1'b0;
            issue(DSRC_REF, 1'b0, lat);
            @(posedge clock);
            #1;
            checkVal({9'h000, extraPending}, 12'h000);
            afterExit();
        end
        $display("test extra refresh done");
    endtask
    task automatic t_exitdelay();
        int lat, exp;
        @(posedge clock);
        refreshMode <= `DSRC_MODE_1X;
        for (int a = 0; a < 2; a++)
        begin
            @(posedge clock);
            abortEnable <= a[0];
            exp = a ? `DSRC_XSA_CYC : `DSRC_XS_CYC;
            enterSr();
            // A long stay lets the aborting exit land inside a running internal refresh.
            exitSr(a ? 34 : 4);
            issue(DSRC_REF, 1'b0, lat);
            checkBit(lat >= exp - 3 && lat <= exp + 3, 1'b1);
            checkBit(abortPulses == abortMark + a, 1'b1);
            checkVal(refreshCount, 12'(countMark));
            afterExit();
        end
        $display("test exit delay done");
    endtask
    task automatic t_rdwait();
        int lat;
        enterSr();
        exitSr(4);
        issue(DSRC_RD, 1'b0, lat);
        checkBit(lat >= XSDLL - 3 && lat <= XSDLL + 3, 1'b1);
        checkBit(dllLocked, 1'b1);
        afterExit();
        issue(DSRC_REF, 1'b0, lat);
        $display("test read wait done");
    endtask
    task automatic end_sim();
        $display("counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_otf();
        t_extra();
        t_exitdelay();
        t_rdwait();
        end_sim();
    end
    initial
    begin
        repeat (20000) @(posedge clock);
        failures++;
        end_sim();
    end
endmodule // testbench
